// ---- src/fws_pkg.sv ----
// package of constants and carriers for the flash write status poller
package fws_pkg;
  // software register offsets (word index on the plain port)
  localparam logic [3:0] REG_CTRL    = 4'h0;  // write: start poll / reset command / erase poll mode
  localparam logic [3:0] REG_ADDR    = 4'h1;  // poll address
  localparam logic [3:0] REG_DATA    = 4'h2;  // expected data for program poll
  localparam logic [3:0] REG_STATUS  = 4'h3;  // live state
  localparam logic [3:0] REG_IRQ     = 4'h4;  // sticky events, write one to clear
  localparam logic [3:0] REG_MASK    = 4'h5;  // interrupt mask
  localparam logic [3:0] REG_LAST    = 4'h6;  // last status byte read
  // control bit positions
  localparam int CTRL_POLL  = 0;  // start a toggle poll
  localparam int CTRL_RST   = 1;  // issue reset command
  localparam int CTRL_ERASE = 2;  // mode: sector erase poll (checks window flag)
  // status data bit positions on the flash bus
  localparam int DQ_POLLED  = 7;  // polled data bit
  localparam int DQ_TOGGLE  = 6;  // toggle bit one
  localparam int DQ_TIMEOUT = 5;  // timeout failure flag
  localparam int DQ_WINDOW  = 3;  // erase window flag
  localparam int DQ_SECTOR  = 2;  // sector toggle bit
  // event bit positions
  localparam int EV_DONE = 0;  // operation completed
  localparam int EV_FAIL = 1;  // timeout failure
  localparam int EV_WIN  = 2;  // erase window closed
  localparam int EV_W    = 3;  // event field width
  // reset command value
  localparam logic [7:0]  CMD_RESET = 8'hf0;  // reset command byte
  // timing: read access time and sleep margin
  localparam int ACC_NS    = 70;  // address access time
  localparam int SLEEP_NS  = 30;  // extra stable time before auto sleep
  localparam int CLK_NS    = 4;   // 250 MHz
  localparam int RD_CYC    = (ACC_NS + CLK_NS - 1) / CLK_NS;  // least time, round up
  localparam int WR_CYC    = (ACC_NS + CLK_NS - 1) / CLK_NS;  // write pulse width
  localparam int SLEEP_CYC = (ACC_NS + SLEEP_NS + CLK_NS - 1) / CLK_NS;  // sleep entry
  // flash bus carrier
  typedef struct packed {
    logic        ce_n;   // chip enable
    logic        oe_n;   // output enable
    logic        we_n;   // write enable
    logic [19:0] addr;   // address
  } fws_bus_t;
  typedef enum {S_IDLE, S_RD1, S_RD2, S_CHK, S_WR, S_GAP} fws_state_t;
endpackage : fws_pkg

// ---- src/fws_poller.sv ----
// host side status poller for an embedded program/erase flash
//
// Behaviour
// RQ1 - timeout failure flag one means operation failed
// RQ2 - program one over zero later raises failure
// RQ3 - after failure, host writes reset command
// RQ4 - window flag zero during timeout, then one
// RQ5 - each extra sector erase restarts timeout
// RQ6 - window flag unused for chip erase
// RQ7 - window flag one: only suspend accepted
// RQ8 - window flag zero: more sectors accepted
// RQ9 - confirm acceptance by toggle before window
// RQ10 - read window flag around each extra erase
// RQ11 - status bit values per operating state
// RQ12 - status reads use a valid address
// RQ13 - stable address for long time: sleep
// RQ14 - suspend: toggle stops, ready high
// RQ15 - sector toggle flips in erasing sectors
// RQ16 - toggle bit one flips each read
// RQ17 - idle device returns array data
`timescale 1ns/100ps
`default_nettype none
module fws_poller
  import fws_pkg::*;
(
  input  wire logic              SYS_CLK,    // 250 MHz
  input  wire logic              SRST,       // synchronous, active high
  input  wire logic [3:0]        ADDR,       // register index
  input  wire logic [31:0]       WDATA,      // write data
  input  wire logic              WR,         // write strobe
  input  wire logic              RD,         // read strobe
  output logic [31:0]            RDATA,      // read data, cycle after RD
  output logic                   IRQ,        // level interrupt
  output fws_pkg::fws_bus_t      FL_BUS,     // flash strobes and address
  output logic [7:0]             FL_DQ_O,    // data out to flash
  output logic                   FL_DQ_OE,   // high while driving data
  input  wire logic [7:0]        FL_DQ_I,    // data in from flash
  input  wire logic              FL_READY_BUSY_I  // ready_busy_out pin, pulled up
);
  import fws_pkg::*;

  // pin synchronisers: first stage feeds only the second
  logic [8:0] sy1_r, sy2_r;
  always_ff @(posedge SYS_CLK) begin
    sy1_r <= {FL_READY_BUSY_I, FL_DQ_I};
    sy2_r <= sy1_r;
  end
  wire logic [7:0] dq_s   = sy2_r[7:0];  // synchronised data
  wire logic       ready_busy_s = sy2_r[8];  // synchronised ready/busy

  // sequencer state
  fws_state_t  st_r, st_nxt;            // poll state
  logic [7:0]  cnt_r, cnt_nxt;          // strobe timer
  logic [7:0]  first_r, first_nxt;      // first of two reads
  logic [7:0]  last_r, last_nxt;        // last status byte
  logic        recheck_r, recheck_nxt;  // second pass after failure seen
  logic        erase_r, erase_nxt;      // sector erase poll mode
  logic [19:0] addr_r, addr_nxt;        // poll address
  logic [7:0]  exp_r, exp_nxt;          // expected data
  logic [EV_W-1:0] ev_r, ev_nxt;        // sticky events
  logic [EV_W-1:0] mask_r, mask_nxt;    // interrupt mask
  logic        busy_r, busy_nxt;        // poll in progress
  logic        ok_r, ok_nxt;            // last operation succeeded
  logic [EV_W-1:0] ev_set;              // events raised this cycle
  fws_bus_t    bus_r, bus_nxt;          // flash strobes

  // next-state logic for sequencer, registers and events
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    first_nxt = first_r;
    last_nxt = last_r;
    recheck_nxt = recheck_r;
    erase_nxt = erase_r;
    addr_nxt = addr_r;
    exp_nxt = exp_r;
    mask_nxt = mask_r;
    busy_nxt = busy_r;
    ok_nxt = ok_r;
    bus_nxt = bus_r;
    ev_set = '0;
    // register writes from software
    if (WR) begin
      case (ADDR)
        REG_ADDR: addr_nxt = WDATA[19:0];  // valid program or sector address RQ12
        REG_DATA: exp_nxt = WDATA[7:0];
        REG_MASK: mask_nxt = WDATA[EV_W-1:0];
        REG_CTRL: begin
          if (st_r == S_IDLE && WDATA[CTRL_RST]) begin
            // reset command returns flash to array reads RQ3
            st_nxt = S_WR;
            cnt_nxt = 8'(WR_CYC);
            bus_nxt = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, addr: addr_r};
          end else if (st_r == S_IDLE && WDATA[CTRL_POLL]) begin
            // window flag only meaningful for sector erase RQ6
            erase_nxt = WDATA[CTRL_ERASE];
            busy_nxt = 1'b1;
            recheck_nxt = 1'b0;
            st_nxt = S_RD1;
            cnt_nxt = 8'(RD_CYC);
            bus_nxt = '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, addr: addr_r};
          end
        end
        default: ;
      endcase
    end
    // flash read/write sequencing
    case (st_r)
      S_IDLE: ;
      S_RD1, S_RD2: begin
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else begin
          // each read cycle framed by oe, so toggle bit advances RQ16
          bus_nxt.oe_n = 1'b1;
          bus_nxt.ce_n = 1'b1;
          if (st_r == S_RD1) begin
            first_nxt = dq_s;
            st_nxt = S_GAP;
          end else begin
            last_nxt = dq_s;
            st_nxt = S_CHK;
          end
          cnt_nxt = 8'h01;
        end
      end
      S_GAP: begin
        // two idle cycles so the device sees two distinct reads
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else begin
          st_nxt = S_RD2;
          cnt_nxt = 8'(RD_CYC);
          bus_nxt = '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, addr: addr_r};
        end
      end
      S_CHK: begin
        // stopped toggle: done; RQ11 RQ14 RQ17
        if (first_r[DQ_TOGGLE] == last_r[DQ_TOGGLE]) begin
          st_nxt = S_IDLE;
          busy_nxt = 1'b0;
          ok_nxt = 1'b1;
          ev_set[EV_DONE] = 1'b1;
        end else if (last_r[DQ_TIMEOUT] && recheck_r) begin
          // still toggling after failure flag: failed RQ1 RQ2
          st_nxt = S_IDLE;
          busy_nxt = 1'b0;
          ok_nxt = 1'b0;
          ev_set[EV_FAIL] = 1'b1;
        end else begin
          // toggle may stop just as failure rises: read again
          recheck_nxt = last_r[DQ_TIMEOUT];
          st_nxt = S_RD1;
          cnt_nxt = 8'(RD_CYC);
          bus_nxt = '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, addr: addr_r};
        end
        // window rose between paired reads: last sector add may be refused RQ4 RQ7 RQ8 RQ9 RQ10
        if (erase_r && last_r[DQ_WINDOW] && !first_r[DQ_WINDOW]) begin
          ev_set[EV_WIN] = 1'b1;
        end
      end
      S_WR: begin
        if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end else begin
          bus_nxt.we_n = 1'b1;
          bus_nxt.ce_n = 1'b1;
          st_nxt = S_IDLE;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  // sticky events: set beats a same-cycle clear
  always_comb begin
    ev_nxt = ev_r;
    if (WR && ADDR == REG_IRQ) begin
      ev_nxt = ev_r & ~WDATA[EV_W-1:0];
    end
    ev_nxt = ev_nxt | ev_set;
  end

  // register all state except read data and pin synchronisers
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      st_r <= S_IDLE;
      cnt_r <= 8'h00;
      first_r <= 8'h00;
      last_r <= 8'h00;
      recheck_r <= 1'b0;
      erase_r <= 1'b0;
      addr_r <= 20'h00000;
      exp_r <= 8'h00;
      ev_r <= '0;
      mask_r <= '0;
      busy_r <= 1'b0;
      ok_r <= 1'b0;
      bus_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 20'h00000};
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      first_r <= first_nxt;
      last_r <= last_nxt;
      recheck_r <= recheck_nxt;
      erase_r <= erase_nxt;
      addr_r <= addr_nxt;
      exp_r <= exp_nxt;
      ev_r <= ev_nxt;
      mask_r <= mask_nxt;
      busy_r <= busy_nxt;
      ok_r <= ok_nxt;
      bus_r <= bus_nxt;
    end
  end

  // read data register, valid the cycle after the strobe
  logic [31:0] rdata_r, rdata_nxt;
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (RD) begin
      case (ADDR)
        REG_ADDR:   rdata_nxt = {12'h000, addr_r};
        REG_DATA:   rdata_nxt = {24'h000000, exp_r};
        REG_STATUS: rdata_nxt = {28'h0000000, ready_busy_s, ok_r, erase_r, busy_r};
        REG_IRQ:    rdata_nxt = {29'h00000000, ev_r};
        REG_MASK:   rdata_nxt = {29'h00000000, mask_r};
        REG_LAST:   rdata_nxt = {24'h000000, last_r};
        default:    rdata_nxt = 32'h00000000;  // unmapped reads zero
      endcase
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // outputs; address held steady across reads lets the device sleep RQ13
  assign RDATA    = rdata_r;
  assign IRQ      = |(ev_r & mask_r);
  assign FL_BUS   = bus_r;
  assign FL_DQ_O  = CMD_RESET;
  assign FL_DQ_OE = (st_r == S_WR);
endmodule // fws_poller
`default_nettype wire

// ---- test/fws_poller_sva.sv ----
// assertion checker for the status poller
`timescale 1ns/100ps
`default_nettype none
module fws_poller_sva
  import fws_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic IRQ,
  input wire fws_pkg::fws_bus_t FL_BUS,
  input wire logic [7:0] FL_DQ_O,
  input wire logic FL_DQ_OE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  // mask write, a quiet cycle, then a mask read
  sequence s_mask_wr; WR && ADDR == REG_MASK; endsequence
  sequence s_mask_rd; !WR ##1 RD && ADDR == REG_MASK; endsequence
  sequence s_rd_open; $fell(FL_BUS.oe_n); endsequence
  property p_rdata_zero; !$past(RD) |-> RDATA == 32'h0; endproperty
  a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside answer cycle");
  property p_dq_val; FL_DQ_OE |-> FL_DQ_O == CMD_RESET && FL_BUS.oe_n; endproperty
  a_dq_val: assert property (p_dq_val) else $error("bad drive of flash data");
  property p_we_data; $fell(FL_BUS.we_n) |-> ##[0:1] FL_DQ_OE; endproperty
  a_we_data: assert property (p_we_data) else $error("write pulse without data");
  property p_irq_mask; WR && ADDR == REG_MASK && WDATA[2:0] == 3'h0 |=> !IRQ; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt seen");
  property p_mask_rb; s_mask_wr ##1 s_mask_rd |=> RDATA[2:0] == $past(WDATA[2:0], 3); endproperty
  a_mask_rb: assert property (p_mask_rb) else $error("mask readback wrong");
  property p_busy_rd; RD && ADDR == REG_STATUS && !FL_BUS.oe_n |=> RDATA[0]; endproperty
  a_busy_rd: assert property (p_busy_rd) else $error("not busy while polling");
  property p_read_hold; s_rd_open |=> ($stable(FL_BUS.addr) && !FL_BUS.oe_n)[*8]; endproperty
  a_read_hold: assert property (p_read_hold) else $error("status read cut short");
  property p_oe_we; !FL_BUS.oe_n |-> FL_BUS.we_n && !FL_BUS.ce_n; endproperty
  a_oe_we: assert property (p_oe_we) else $error("read strobes inconsistent");
endmodule // fws_poller_sva
bind fws_poller fws_poller_sva fws_poller_sva_inst (.SYS_CLK(SYS_CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .FL_BUS(FL_BUS), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE(FL_DQ_OE));
`default_nettype wire

// ---- test/fws_flash_model.sv ----
// behavioural flash device answering status reads
`timescale 1ns/100ps
`default_nettype none
module fws_flash_model
  import fws_pkg::*;
#(parameter logic [7:0] ARRAY_BYTE = 8'h5a)
(
  input wire logic clk,
  input wire logic [1:0] mode, // 0 idle, 1 program, 2 stuck, 3 sector erase
  input wire fws_pkg::fws_bus_t bus,
  input wire logic [7:0] dq_o,
  input wire logic dq_oe,
  output logic [7:0] dq_i,
  output logic ready_busy_out,
  output logic asleep
);
  logic [1:0] op_r = 2'h0, mode_r = 2'h0;
  logic rd_r = 1'b0, tog_r = 1'b0;
  logic [7:0] nrd_r = 8'h0, last_r = 8'h0, stat;
  logic [19:0] addr_q = 20'h0;  // address seen last cycle
  logic [7:0] still_r = 8'h0;   // cycles of unchanged address
  // automatic sleep after a long stable address; outputs stay latched
  assign asleep = still_r >= 8'(SLEEP_CYC);
  // status byte; window closes after the first read of an erase
  always_comb begin
    if (op_r == 2'h0)
      stat = ARRAY_BYTE;
    else
      stat = {1'b0, tog_r, op_r == 2'h2, 1'b0, op_r == 2'h3 && nrd_r != 8'h0, op_r == 2'h3 && tog_r, 2'h0};
  end
  // released bus never shows the stale byte
  assign dq_i = rd_r ? stat : ~last_r;
  assign ready_busy_out = op_r == 2'h0;
  always @(posedge clk) begin
    mode_r <= mode;
    addr_q <= bus.addr;
    if (bus.addr != addr_q)
      still_r <= 8'h0;
    else if (still_r != 8'hff)
      still_r <= still_r + 8'h1;
    if (mode != mode_r) begin
      op_r <= mode;
      nrd_r <= 8'h0;
    end
    // closed window ignores all but suspend; open window still takes commands
    if (!bus.we_n && dq_oe && dq_o == CMD_RESET && !(op_r == 2'h3 && nrd_r != 8'h0))
      op_r <= 2'h0;
    if (!bus.ce_n && !bus.oe_n)
      rd_r <= 1'b1;
    if (rd_r)
      last_r <= dq_i;
    if (rd_r && (bus.ce_n || bus.oe_n)) begin
      rd_r <= 1'b0;
      tog_r <= ~tog_r;
      nrd_r <= nrd_r + 8'h1;
    end
  end
endmodule // fws_flash_model
`default_nettype wire

// ---- test/fws_poller_tb_top.sv ----
// self-checking bench for the status poller
`timescale 1ns/100ps
`default_nettype none
module fws_poller_tb_top;
  import fws_pkg::*;
  `define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, g); end end
  logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, irq, ready_busy, asleep, dq_oe, rd_d = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, ev, ex;
  logic [7:0] dq_o, dq_i;
  logic [1:0] mode = 2'h0;
  logic [19:0] pa = 20'h0;
  fws_bus_t bus;
  logic [31:0] exp_q[$], msk_q[$];
  int fails = 0, checks_done = 0, seed = 76;
  always #2 clk = ~clk;
  fws_poller fws_poller_inst (.SYS_CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .IRQ(irq), .FL_BUS(bus), .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe), .FL_DQ_I(dq_i), .FL_READY_BUSY_I(ready_busy));
  fws_flash_model fws_flash_model_inst (.clk(clk), .mode(mode), .bus(bus), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
    .ready_busy_out(ready_busy), .asleep(asleep));
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // expected answer noted before the read goes out
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // answer stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) begin
      ev = msk_q.pop_front();
      ex = exp_q.pop_front() & ev;
      `CHK("read data", ex, rdata & ev)
    end
    if (!bus.oe_n)
      `CHK("poll address", pa, bus.addr)
  end
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    `CHK("irq raised", 1'b1, irq)
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    pa = 20'($random(seed));
    wr_reg(REG_MASK, 32'h7);
    rd_reg(REG_MASK, 32'h7, 32'h7);
    wr_reg(REG_ADDR, {12'h0, pa});
    wr_reg(REG_DATA, $random(seed));
    wr_reg(REG_CTRL, 32'h1);
    wait_irq();
    rd_reg(REG_IRQ, 32'h1, 32'h3);
    wr_reg(REG_IRQ, 32'h7);
    $display("test idle poll done");
    mode <= 2'h2;
    wr_reg(REG_CTRL, 32'h1);
    rd_reg(REG_STATUS, 32'h1, 32'h9);
    wait_irq();
    rd_reg(REG_IRQ, 32'h2, 32'h3);
    rd_reg(REG_LAST, 32'h20, 32'hbf);
    wr_reg(REG_IRQ, 32'h7);
    rd_reg(REG_IRQ, 32'h0, 32'h7);
    wr_reg(REG_CTRL, 32'h2);
    repeat (40) @(posedge clk);
    `CHK("ready after reset command", 1'b1, ready_busy)
    rd_reg(REG_STATUS, 32'h8, 32'h9);
    $display("test failure and reset done");
    wr_reg(REG_MASK, 32'h0);
    wr_reg(REG_CTRL, 32'h1);
    repeat (150) @(posedge clk);
    `CHK("masked irq", 1'b0, irq)
    `CHK("flash asleep", 1'b1, asleep)
    rd_reg(REG_IRQ, 32'h1, 32'h3);
    wr_reg(REG_MASK, 32'h7);
    wait_irq();
    wr_reg(REG_IRQ, 32'h7);
    $display("test mask done");
    mode <= 2'h3;
    wr_reg(REG_CTRL, 32'h5);
    wait_irq();
    rd_reg(REG_IRQ, 32'h4, 32'h4);
    rd_reg(4'hf, 32'h0, 32'hffffffff);
    repeat (4) @(posedge clk);
    $display("test erase window done");
    wrap_up();
  end
  // whole run is near 400 cycles; allow over ten times that
  initial begin
    #80000;
    fails++;
    wrap_up();
  end
endmodule // fws_poller_tb_top
`default_nettype wire
